//--- logic/scd_decoder.sv
// Command word decoder driving a SIMD array of byte-wide elements.
// Operation
// - Main opcode first, supplementary word second
// - Bit 30 selects composition queue
// - Bit 28 means supplementary word follows
// - Bit 27 means coefficient words follow
// - Bit 26 selects one or three coefficients
// - Bit 25 selects 32 or 64 bit coefficients
// - Bit 24 marks coefficients floating point
// - Coefficient flags set length for every command
// - Words ordered main, supp, A, B, C
// - Word-order bit swaps halves of 64-bit coefficients
// - All elements run same instruction together
// - Elements take data from one neighbour, next index up, wrapping
// - Memory writes only at enabled elements
// - Carry defined only at enabled elements
// - Scratch register updated at every element
// - Multi-byte integers stored little-endian
// - Bit index 0 to 7, 0 is LSB
// - Addresses 448-511 relocated by base register
// - Base register loaded only by its command
`timescale 1ns/1ns
module scd_decoder #(
    parameter int NPE = 8
) (
    input  wire logic              ref_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              word_valid_i,
    output logic                   word_ready_o,
    input  wire logic [31:0]       word_i,
    input  wire logic              word_swap_i,
    output logic                   exec_o,
    output logic                   exec_queue_o,
    output logic [7:0]             exec_opcode_o,
    output logic [8:0]             mem_addr_o,
    output logic [NPE-1:0]         mem_we_o,
    output logic [NPE*8-1:0]       mem_wdata_o,
    output logic [NPE-1:0]         enable_o,
    output logic [NPE-1:0]         carry_o,
    output logic [NPE*8-1:0]       scratch_o,
    output logic [8:0]             base_o
);
    typedef struct packed {
        scd_pkg::scd_state_t st;
        scd_pkg::scd_cmd_t   cmd;
        logic [2:0]          left;
        logic                hi_half;
        logic                exec;
        logic [8:0]          addr;
        logic [NPE-1:0]      we;
        logic [NPE*8-1:0]    wdata;
        scd_pkg::scd_pe_t [NPE-1:0] pe;
        logic [8:0]          base;
        logic [3:0]          coef_left;
    } scd_st_t;

    scd_st_t     s_q;
    scd_st_t     s_d;
    logic        f_valid;
    logic        f_ready;
    logic [31:0] f_word;
    logic [8:0]  raw_addr;
    logic [8:0]  eff_addr;
    logic [7:0]  opnd;
    logic [2:0]  bit_idx;

    scd_fifo #(.WIDTH(32), .DEPTH(scd_pkg::FIFO_DEPTH)) u_fifo (
        .ref_clk_i  (ref_clk_i),
        .sys_rst_i  (sys_rst_i),
        .in_valid_i (word_valid_i),
        .in_ready_o (word_ready_o),
        .in_data_i  (word_i),
        .out_valid_o(f_valid),
        .out_ready_i(f_ready),
        .out_data_o (f_word)
    );

    // Words are not drained while executing, so a burst backs up the FIFO.
    assign f_ready  = (s_q.st != scd_pkg::ST_EXEC);
    assign raw_addr = s_q.cmd.supp[8:0];
    assign opnd     = s_q.cmd.supp[23:16];
    assign bit_idx  = s_q.cmd.supp[26:24];
    // Upper window maps onto base-relative space.
    assign eff_addr = (raw_addr >= scd_pkg::RELOC_LO) ?
        9'(raw_addr - scd_pkg::RELOC_LO + s_q.base) : raw_addr;

    always_comb begin
        logic [3:0] n;
        logic [63:0] c;
        n = '0;
        c = s_q.cmd.coef_c;
        s_d = s_q;
        s_d.exec = 1'b0;
        s_d.we = '0;
        case (s_q.st)
            scd_pkg::ST_MAIN: begin
                if (f_valid) begin
                    // Main word always opens a command.
                    s_d.cmd.queue_sel = f_word[scd_pkg::QSEL_BIT];
                    s_d.cmd.opcode    = f_word[7:0];
                    s_d.cmd.supp      = '0;
                    s_d.cmd.coef_c    = '0;
                    s_d.cmd.is_float  = f_word[scd_pkg::FLOAT_BIT];
                    s_d.cmd.is_double = f_word[scd_pkg::DOUBLE_BIT];
                    s_d.hi_half = 1'b0;
                    // Count of coefficient words, even for hidden C.
                    if (f_word[scd_pkg::COEF_BIT]) begin
                        n = f_word[scd_pkg::LINEAR_BIT] ? 4'd3 : 4'd1;
                        if (f_word[scd_pkg::DOUBLE_BIT]) begin
                            n = 4'(n << 1);
                        end
                    end
                    s_d.coef_left = n;
                    if (f_word[scd_pkg::LONG_BIT]) begin
                        s_d.st = scd_pkg::ST_SUPP;
                    end else if (n != 4'd0) begin
                        s_d.st = scd_pkg::ST_COEF;
                    end else begin
                        s_d.st = scd_pkg::ST_EXEC;
                    end
                end
            end
            scd_pkg::ST_SUPP: begin
                if (f_valid) begin
                    s_d.cmd.supp = f_word;
                    s_d.st = (s_q.coef_left != 4'd0) ?
                        scd_pkg::ST_COEF : scd_pkg::ST_EXEC;
                end
            end
            scd_pkg::ST_COEF: begin
                if (f_valid) begin
                    // A, B then C arrive in order; C is the last kept.
                    if (s_q.cmd.is_double) begin
                        if (s_q.hi_half ^ word_swap_i) begin
                            c[63:32] = f_word;
                        end else begin
                            c[31:0] = f_word;
                        end
                        s_d.hi_half = ~s_q.hi_half;
                    end else begin
                        c = {{32{f_word[31]}}, f_word};
                    end
                    s_d.cmd.coef_c = c;
                    s_d.coef_left = s_q.coef_left - 4'd1;
                    if (s_q.coef_left == 4'd1) begin
                        s_d.st = scd_pkg::ST_EXEC;
                    end
                end
            end
            scd_pkg::ST_EXEC: begin
                // One broadcast step applied to every element.
                s_d.exec = 1'b1;
                s_d.addr = eff_addr;
                s_d.st = scd_pkg::ST_MAIN;
                for (int i = 0; i < NPE; i++) begin
                    logic [7:0] nb;
                    nb = s_q.pe[(i + 1) % NPE].s;
                    case (s_q.cmd.opcode)
                        scd_pkg::OP_BASE_LOAD: begin
                            s_d.base = raw_addr;
                        end
                        scd_pkg::OP_WRITE: begin
                            // Low byte of C goes to lowest address.
                            s_d.wdata[i*8 +: 8] = s_q.cmd.coef_c[7:0];
                            s_d.we[i] = s_q.pe[i].en;
                        end
                        scd_pkg::OP_SET_ENAB: begin
                            s_d.pe[i].en = opnd[0];
                        end
                        scd_pkg::OP_SET_CARRY: begin
                            if (s_q.pe[i].en) begin
                                s_d.pe[i].carry = opnd[0];
                            end
                        end
                        scd_pkg::OP_LOAD_S: begin
                            s_d.pe[i].s = opnd;
                        end
                        scd_pkg::OP_SHIFT_NB: begin
                            s_d.pe[i].s = nb;
                        end
                        scd_pkg::OP_BIT_WRITE: begin
                            s_d.wdata[i*8 +: 8] = 8'h01 << bit_idx;
                            s_d.we[i] = s_q.pe[i].en;
                        end
                        default: begin
                            s_d.we[i] = 1'b0;
                        end
                    endcase
                end
            end
            default: begin
                s_d.st = scd_pkg::ST_MAIN;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
            s_q.st <= scd_pkg::ST_MAIN;
            s_q.base <= scd_pkg::BASE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            exec_o        <= 1'b0;
            exec_queue_o  <= 1'b0;
            exec_opcode_o <= '0;
        end else begin
            exec_o        <= s_d.exec;
            exec_queue_o  <= s_q.cmd.queue_sel;
            exec_opcode_o <= s_q.cmd.opcode;
        end
    end

    assign mem_addr_o  = s_q.addr;
    assign mem_we_o    = s_q.we;
    assign mem_wdata_o = s_q.wdata;
    assign base_o      = s_q.base;

    for (genvar g = 0; g < NPE; g++) begin : g_pe
        assign enable_o[g]        = s_q.pe[g].en;
        assign carry_o[g]         = s_q.pe[g].carry;
        assign scratch_o[g*8 +: 8] = s_q.pe[g].s;
    end

    exec_once_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        s_q.st == scd_pkg::ST_EXEC |=> s_q.st == scd_pkg::ST_MAIN)
        else $error("exec state lasted more than one cycle");
    long_bit_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        s_q.st == scd_pkg::ST_MAIN && f_valid && f_word[scd_pkg::LONG_BIT]
        |=> s_q.st == scd_pkg::ST_SUPP)
        else $error("long bit did not expect supplementary word");
    no_coef_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        s_q.st == scd_pkg::ST_MAIN && f_valid &&
        !f_word[scd_pkg::LONG_BIT] && !f_word[scd_pkg::COEF_BIT]
        |=> s_q.st == scd_pkg::ST_EXEC)
        else $error("command without coefficients not executed");
    coef_len_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        s_q.st == scd_pkg::ST_MAIN && f_valid && !f_word[scd_pkg::LONG_BIT]
        && f_word[scd_pkg::COEF_BIT] && f_word[scd_pkg::LINEAR_BIT]
        && f_word[scd_pkg::DOUBLE_BIT] |=> s_q.coef_left == 4'd6)
        else $error("linear double needs six words");
    queue_sel_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        s_q.st == scd_pkg::ST_MAIN && f_valid
        |=> s_q.cmd.queue_sel == $past(f_word[scd_pkg::QSEL_BIT]))
        else $error("queue select not captured");
    we_enab_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (s_q.we & ~enable_o) == '0)
        else $error("write at disabled element");
    reloc_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        s_q.st == scd_pkg::ST_EXEC && raw_addr == 9'h1c0
        |=> s_q.addr == $past(s_q.base))
        else $error("relocated address wrong");
    base_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !(s_q.st == scd_pkg::ST_EXEC
          && s_q.cmd.opcode == scd_pkg::OP_BASE_LOAD) |=> $stable(s_q.base))
        else $error("base changed without base load");
    no_drain_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        s_q.st == scd_pkg::ST_EXEC |-> !f_ready)
        else $error("word taken during execute");
endmodule : scd_decoder

//--- logic/scd_fifo.sv
// Parameterised valid/ready FIFO for incoming command words.
`timescale 1ns/1ns
module scd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;
    logic [AW:0]      wp_d;
    logic [AW:0]      rp_d;
    logic             ready_q;
    logic             push;
    logic             pop;

    // Ready is registered from the next pointers so it leaves a flip-flop
    // while still saying exactly what the current pointers would say.
    assign in_ready_o  = ready_q;
    assign wp_d        = wp_q + (AW+1)'(push);
    assign rp_d        = rp_q + (AW+1)'(pop);
    assign out_valid_o = wp_q != rp_q;
    assign out_data_o  = mem[rp_q[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wp_q    <= '0;
            rp_q    <= '0;
            ready_q <= 1'b1;
        end else begin
            wp_q    <= wp_d;
            rp_q    <= rp_d;
            ready_q <= (wp_d - rp_d) != (AW+1)'(DEPTH);
        end
    end
endmodule : scd_fifo

//--- logic/scd_pkg.sv
// Package of constants and carrier types for the command word decoder.
package scd_pkg;
    localparam int QSEL_BIT   = 30;
    localparam int LONG_BIT   = 28;
    localparam int COEF_BIT   = 27;
    localparam int LINEAR_BIT = 26;
    localparam int DOUBLE_BIT = 25;
    localparam int FLOAT_BIT  = 24;
    localparam logic [8:0] RELOC_LO   = 9'h1c0;
    localparam logic [8:0] RELOC_HI   = 9'h1ff;
    localparam logic [8:0] BASE_RESET = 9'h000;
    localparam logic [7:0] OP_BASE_LOAD = 8'h01;
    localparam logic [7:0] OP_WRITE     = 8'h02;
    localparam logic [7:0] OP_SET_ENAB  = 8'h03;
    localparam logic [7:0] OP_SET_CARRY = 8'h04;
    localparam logic [7:0] OP_LOAD_S    = 8'h05;
    localparam logic [7:0] OP_SHIFT_NB  = 8'h06;
    localparam logic [7:0] OP_BIT_WRITE = 8'h07;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [3:0] {
        ST_MAIN = 4'h1,
        ST_SUPP = 4'h2,
        ST_COEF = 4'h4,
        ST_EXEC = 4'h8
    } scd_state_t;

    typedef struct packed {
        logic        queue_sel;
        logic [7:0]  opcode;
        logic [31:0] supp;
        logic        is_float;
        logic        is_double;
        logic [63:0] coef_c;
    } scd_cmd_t;

    typedef struct packed {
        logic        en;
        logic        carry;
        logic [7:0]  s;
    } scd_pe_t;
endpackage : scd_pkg

//--- test/scd_decoder_tb_top.sv
// Self-checking bench for the command word decoder.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin \
    n_fail++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module scd_decoder_tb_top;
    typedef struct packed {
        logic        q;
        logic [7:0]  op;
        logic [8:0]  addr;
        logic [7:0]  we;
        logic [7:0]  wd;
        logic        chk_wd;
        logic [7:0]  en;
        logic [7:0]  cy;
        logic [63:0] sc;
        logic [8:0]  base;
    } scd_note_t;

    logic        ref_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        swap      = 1'b0;
    logic        stall     = 1'b0;
    logic        saw_full  = 1'b0;
    logic        valid;
    logic        ready;
    logic [31:0] word;
    logic        exec;
    logic        exec_queue;
    logic [7:0]  exec_opcode;
    logic [8:0]  mem_addr;
    logic [7:0]  mem_we;
    logic [63:0] mem_wdata;
    logic [7:0]  enable;
    logic [7:0]  carry;
    logic [63:0] scratch;
    logic [8:0]  base;
    logic [7:0]  en_m = 8'h00;
    logic [7:0]  cy_m = 8'h00;
    logic [63:0] sc_m = 64'h0;
    logic [8:0]  base_m = 9'h000;
    scd_note_t   notes[$];
    scd_note_t   nt;
    int          n_fail = 0;
    int          samples_checked = 0;

    always #50 ref_clk_i = ~ref_clk_i;

    scd_host_model scd_host_model_i (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .ready_i(ready), .stall_i(stall),
        .valid_o(valid), .word_o(word));

    scd_decoder #(.NPE(8)) scd_decoder_i (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .word_valid_i(valid), .word_ready_o(ready),
        .word_i(word), .word_swap_i(swap), .exec_o(exec),
        .exec_queue_o(exec_queue), .exec_opcode_o(exec_opcode),
        .mem_addr_o(mem_addr), .mem_we_o(mem_we), .mem_wdata_o(mem_wdata),
        .enable_o(enable), .carry_o(carry), .scratch_o(scratch),
        .base_o(base));

    function automatic logic [31:0] mk(input logic q, input logic l,
                                       input logic [3:0] f,
                                       input logic [7:0] op);
        mk = {1'b0, q, 1'b0, l, f, 16'h0000, op};
    endfunction : mk

    task automatic final_report;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // Queues the words of one command and notes what its execution must show.
    task automatic cmd(input logic [31:0] mw, input logic [31:0] sw,
                       input logic [63:0] cv);
        scd_note_t   n;
        logic [63:0] v;
        n = '0;
        scd_host_model_i.words_q.push_back(mw);
        if (mw[scd_pkg::LONG_BIT]) scd_host_model_i.words_q.push_back(sw);
        for (int k = 0; k < (mw[27] ? (mw[26] ? 3 : 1) : 0); k++) begin
            // A and B carry the inverse of C so a wrong pick shows.
            v = (mw[26] && k < 2) ? ~cv : cv;
            if (mw[25]) begin
                scd_host_model_i.words_q.push_back(swap ? v[63:32] : v[31:0]);
                scd_host_model_i.words_q.push_back(swap ? v[31:0] : v[63:32]);
            end else begin
                scd_host_model_i.words_q.push_back(v[31:0]);
            end
        end
        n.q  = mw[scd_pkg::QSEL_BIT];
        n.op = mw[7:0];
        case (mw[7:0])
            scd_pkg::OP_BASE_LOAD: base_m = sw[8:0];
            scd_pkg::OP_SET_ENAB:  en_m = {8{sw[16]}};
            scd_pkg::OP_SET_CARRY: cy_m = (cy_m & ~en_m) | (en_m & {8{sw[16]}});
            scd_pkg::OP_LOAD_S:    sc_m = {8{sw[23:16]}};
            scd_pkg::OP_SHIFT_NB:  sc_m = {sc_m[7:0], sc_m[63:8]};
            default: begin
                n.we     = en_m;
                n.addr   = (sw[8:0] >= scd_pkg::RELOC_LO) ?
                           sw[8:0] - scd_pkg::RELOC_LO + base_m : sw[8:0];
                // Single-byte segments stay inside one partition.
                n.wd     = (mw[7:0] == scd_pkg::OP_BIT_WRITE) ?
                           8'h01 << sw[26:24] : cv[7:0];
                n.chk_wd = 1'b1;
            end
        endcase
        n.en   = en_m;
        n.cy   = cy_m;
        n.sc   = sc_m;
        n.base = base_m;
        notes.push_back(n);
    endtask : cmd

    task automatic wait_idle;
        int k;
        for (k = 0; k < 3000 && (notes.size() > 0 ||
             scd_host_model_i.words_q.size() > 0); k++) @(negedge ref_clk_i);
        if (k == 3000) begin
            n_fail++;
            $display("unexpected idle exp 1 got 0");
            final_report();
        end
        repeat (4) @(negedge ref_clk_i);
    endtask : wait_idle

    always @(negedge ref_clk_i) begin
        if (!sys_rst_i && ready === 1'b0) saw_full = 1'b1;
        if (!sys_rst_i && exec === 1'b1) begin
            if (notes.size() == 0) begin
                n_fail++;
                $display("unexpected exec_o exp 0 got 1");
            end else begin
                nt = notes.pop_front();
                `CHK("exec_queue_o", nt.q, exec_queue)
                `CHK("exec_opcode_o", nt.op, exec_opcode)
                `CHK("mem_we_o", nt.we, mem_we)
                if (nt.we != 8'h00) `CHK("mem_addr_o", nt.addr, mem_addr)
                for (int i = 0; i < 8; i++)
                    if (nt.chk_wd && nt.we[i]) `CHK("mem_wdata_o", nt.wd, mem_wdata[i*8+:8])
                `CHK("enable_o", nt.en, enable)
                `CHK("carry_o", nt.cy, carry)
                `CHK("scratch_o", nt.sc, scratch)
                `CHK("base_o", nt.base, base)
            end
        end
    end

    initial begin
        logic [31:0] sw;
        void'($urandom(32'h411821cb));
        repeat (5) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        @(negedge ref_clk_i);
        `CHK("base_o", scd_pkg::BASE_RESET, base)
        `CHK("enable_o", 8'h00, enable)
        `CHK("scratch_o", 64'h0, scratch)
        $display("test reset_values done");
        // Random host gaps keep the last word late, so early execution shows.
        stall = 1'b1;
        cmd(mk(0, 1, 4'h0, scd_pkg::OP_SET_ENAB), 32'h0001_0000, 64'h0);
        for (int s = 0; s < 2; s++) begin
            swap = s[0];
            for (int f = 8; f < 16; f++) begin
                sw = {23'h0, 9'($urandom_range(447, 0))};
                cmd(mk(0, 1, f[3:0], scd_pkg::OP_WRITE), sw, {$urandom, $urandom});
            end
            wait_idle();
        end
        swap = 1'b0;
        $display("test coefficient_formats done");
        cmd(mk(1, 1, 4'h0, scd_pkg::OP_SET_CARRY), 32'h0001_0000, 64'h0);
        cmd(mk(1, 1, 4'h0, scd_pkg::OP_SET_ENAB), 32'h0000_0000, 64'h0);
        cmd(mk(1, 1, 4'h0, scd_pkg::OP_SET_CARRY), 32'h0000_0000, 64'h0);
        cmd(mk(1, 1, 4'h0, scd_pkg::OP_LOAD_S), {8'h00, 8'($urandom), 16'h0}, 64'h0);
        cmd(mk(1, 0, 4'h0, scd_pkg::OP_SHIFT_NB), 32'h0, 64'h0);
        cmd(mk(0, 0, 4'he, scd_pkg::OP_SHIFT_NB), 32'h0, {$urandom, $urandom});
        cmd(mk(0, 1, 4'h8, scd_pkg::OP_WRITE), 32'h0000_0010, 64'h5a);
        cmd(mk(1, 1, 4'h0, scd_pkg::OP_SET_ENAB), 32'h0001_0000, 64'h0);
        cmd(mk(1, 1, 4'h0, scd_pkg::OP_BIT_WRITE), 32'h0700_0021, 64'h0);
        wait_idle();
        $display("test element_state done");
        cmd(mk(1, 1, 4'h0, scd_pkg::OP_BASE_LOAD), 32'h0000_01f0, 64'h0);
        for (int j = 0; j < 4; j++) begin
            sw = {23'h0, j == 0 ? 9'h1bf : j == 1 ? 9'h1c0 : j == 2 ? 9'h1ff : 9'h1c5};
            cmd(mk(0, 1, 4'h8, scd_pkg::OP_WRITE), sw, {$urandom, $urandom});
        end
        cmd(mk(0, 1, 4'h0, scd_pkg::OP_BASE_LOAD), 32'h0000_0005, 64'h0);
        cmd(mk(0, 1, 4'h8, scd_pkg::OP_WRITE), 32'h0000_01c0, 64'h3c);
        wait_idle();
        $display("test relocation done");
        // Single-word commands arrive faster than the decoder retires them.
        stall = 1'b0;
        repeat (40) cmd(mk(0, 0, 4'h0, scd_pkg::OP_SHIFT_NB), 32'h0, 64'h0);
        wait_idle();
        `CHK("word_ready_o low seen", 1'b1, saw_full)
        `CHK("word_ready_o", 1'b1, ready)
        $display("test fifo_fill done");
        final_report();
    end
endmodule : scd_decoder_tb_top

//--- test/scd_host_model.sv
// Host model that streams queued 32-bit command words into the decoder.
`timescale 1ns/1ns
module scd_host_model (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ready_i,
    input  wire logic        stall_i,
    output logic             valid_o,
    output logic [31:0]      word_o
);
    logic [31:0] words_q[$];
    logic        taken_q = 1'b0;

    initial begin
        valid_o = 1'b0;
        word_o  = 32'h0000_0000;
    end

    // A word counts as delivered only at the rising edge that sees ready.
    always @(posedge ref_clk_i) begin
        taken_q <= valid_o && ready_i;
    end

    // Words leave strictly in queue order; the bench builds each command
    // whole, with no padding of its own, and keeps coefficient commands off
    // the composition queue.
    always @(negedge ref_clk_i) begin
        if (sys_rst_i) begin
            valid_o = 1'b0;
        end else if (taken_q || !valid_o) begin
            if (words_q.size() > 0 && !(stall_i && $urandom_range(1, 0) == 0)) begin
                word_o  = words_q.pop_front();
                valid_o = 1'b1;
            end else begin
                // A released data line must not keep looking like a word.
                valid_o = 1'b0;
                word_o  = ~word_o;
            end
        end
    end
endmodule : scd_host_model
